/* File: poc_pkg.sv */
// package: register map, reset values and timing constants of the position output stage
`default_nettype none
package poc_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam int LIN_POINTS = 33;
    // register word addresses
    localparam logic [7:0] ADDR_ANGLE_REFERENCE = 8'h00;
    localparam logic [7:0] ADDR_RANGE_PRESHIFT = 8'h01;
    localparam logic [7:0] ADDR_OUTPUT_SCALE = 8'h02;
    localparam logic [7:0] ADDR_OUTPUT_SHIFT = 8'h03;
    localparam logic [7:0] ADDR_LOWER_LIMIT = 8'h04;
    localparam logic [7:0] ADDR_UPPER_LIMIT = 8'h05;
    localparam logic [7:0] ADDR_FIELD_FLOOR = 8'h06;
    localparam logic [7:0] ADDR_FIELD_CEILING = 8'h07;
    localparam logic [7:0] ADDR_SMOOTHING = 8'h08;
    localparam logic [7:0] ADDR_USER_SETUP = 8'h09;
    localparam logic [7:0] ADDR_SEGMENT_REPEAT = 8'h0A;
    localparam logic [7:0] ADDR_DIAG_STATUS = 8'h0B;
    localparam logic [7:0] ADDR_ANGLE_RESULT = 8'h0C;
    localparam logic [7:0] ADDR_OUTPUT_VALUE = 8'h0D;
    localparam logic [7:0] ADDR_LIN_BASE = 8'h20;
    // user_setup_word bit positions
    localparam int SETUP_LOCK = 0;
    localparam int SETUP_DIAG_NOFORCE = 1;
    localparam int SETUP_DIAG_LATCH = 2;
    localparam int SETUP_OVERVOLT = 3;
    localparam int SETUP_PIN_TALK = 4;
    localparam int SETUP_FUNC_NORMAL = 5;
    localparam int SETUP_BURN_IN = 6;
    localparam int SETUP_BAND_LOW = 7;
    localparam int SETUP_SHORT_LSB = 8;
    localparam int SETUP_RATE_LSB = 10;
    localparam int SETUP_FORMAT = 12;
    localparam int SETUP_FAST_BIT = 13;
    localparam int SETUP_SELFTEST = 14;
    // reset values
    localparam logic [15:0] RST_ZERO = 16'h0000;
    localparam logic [15:0] RST_SCALE = 16'h0200;
    localparam logic [15:0] RST_UPPER = 16'h4000;
    localparam logic [15:0] RST_CEILING = 16'h7FFF;
    localparam logic [15:0] LIN_STEP = 16'h0400;
    // number formats
    localparam int SCALE_FRAC = 10;
    localparam logic [15:0] MOD120_SPAN = 16'h5555;
    // timing
    localparam longint CLK_HZ = 200000000;
    localparam longint BIT_TIME_SLOW_US = 1000;
    localparam longint BIT_TIME_FAST_US = 250;
    localparam longint PWM_1K_HZ = 1000;
    localparam longint PWM_500_HZ = 500;
    localparam longint PWM_200_HZ = 200;
    localparam longint PWM_2K_HZ = 2000;
    localparam int PERIOD_W = 20;
    localparam int BIT_SLOW_CYC = int'(CLK_HZ * BIT_TIME_SLOW_US / 1000000);
    localparam int BIT_FAST_CYC = int'(CLK_HZ * BIT_TIME_FAST_US / 1000000);
    localparam int PWM_1K_CYC = int'(CLK_HZ / PWM_1K_HZ);
    localparam int PWM_500_CYC = int'(CLK_HZ / PWM_500_HZ);
    localparam int PWM_200_CYC = int'(CLK_HZ / PWM_200_HZ);
    localparam int PWM_2K_CYC = int'(CLK_HZ / PWM_2K_HZ);
endpackage
`default_nettype wire

/* File: poc_output_stage.sv */
// module: output conditioning path and setup word of the position sensor
// Overview of operation
// - angle_reference is a 16-bit signed register, subtracted as the output reference.
// - range_preshift is added first to keep the 16-bit path from overflowing.
// - output_scale multiplies the output; unity maps 360 degrees to 100 percent.
// - output_shift adds an offset of -100 to 100 percent of full scale.
// - output is clamped between lower and upper output limits.
// - field magnitude outside floor or ceiling forces the output to the upper limit.
// - first-order low-pass filter, strength chosen by smoothing_select.
// - optional repeat of 90 or 120 degree segments over the full turn.
// - 33-point curve, linear interpolation between adjacent setpoints.
// - setpoints spaced 1024 apart from 0 to 32768, starting at the reference.
// - setup bit 14 selects memory self-test at power-up or continuous.
// - setup bit 13 selects protocol bit time 1 ms or 0.25 ms.
// - setup bit 12 selects PWM or SENT output format.
// - setup bits 11:10 select PWM rate 1 kHz, 500 Hz, 200 Hz or 2 kHz.
// - setup bits 9:8 select output short reaction: off, band rail, opposite, tristate on short_low_det only.
// - setup bit 7 selects low error band, honoured only once locked.
// - setup bits 6..3 enable burn-in, normal mode, pin talk and overvoltage check.
// - setup bit 2 latches diagnosis bits until reset or until bit 2 is cleared.
// - setup bit 1 clear lets diagnosis errors force the error band, supply side unless the low band of bit 7 is in force.
// - setup bit 0 locks all registers against further writes.
`default_nettype none
module poc_output_stage #(
    parameter int BIT_SLOW_CYCLES = poc_pkg::BIT_SLOW_CYC,
    parameter int BIT_FAST_CYCLES = poc_pkg::BIT_FAST_CYC,
    parameter int PWM_1K_CYCLES = poc_pkg::PWM_1K_CYC,
    parameter int PWM_500_CYCLES = poc_pkg::PWM_500_CYC,
    parameter int PWM_200_CYCLES = poc_pkg::PWM_200_CYC,
    parameter int PWM_2K_CYCLES = poc_pkg::PWM_2K_CYC
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // register port
    input wire logic [poc_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [poc_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [poc_pkg::DATA_W-1:0] reg_rdata,
    // measurement input
    input wire logic sample_valid,
    input wire logic [15:0] angle_in,
    input wire logic [15:0] magnitude_in,
    input wire logic [7:0] diag_in,
    input wire logic short_high_det,
    input wire logic short_low_det,
    // conditioned output
    output logic result_valid,
    output logic [15:0] result_value,
    output logic error_active,
    output logic error_band_low,
    output logic drive_supply,
    output logic drive_ground,
    output logic drive_tristate,
    // configuration toward the output stage
    output logic selftest_continuous,
    output logic digital_format_select,
    output logic [1:0] pulse_rate_select,
    output logic [poc_pkg::PERIOD_W-1:0] pwm_period,
    output logic [poc_pkg::PERIOD_W-1:0] bit_period,
    output logic burn_in_enable,
    output logic func_normal,
    output logic pin_talk_enable,
    output logic overvolt_enable,
    output logic mem_locked
);
    import poc_pkg::*;

    typedef struct packed {
        logic [15:0] angle_reference;
        logic [15:0] range_preshift;
        logic [15:0] output_scale;
        logic [15:0] output_shift;
        logic [15:0] lower_output_limit;
        logic [15:0] upper_output_limit;
        logic [15:0] field_floor;
        logic [15:0] field_ceiling;
        logic [15:0] smoothing_select;
        logic [15:0] user_setup_word;
        logic [1:0] segment_repeat_select;
        logic [LIN_POINTS-1:0][15:0] lin_point;
        logic [7:0] diag;
        logic field_fault;
        logic [15:0] angle_result;
        logic [15:0] filt;
        logic [15:0] result;
        logic valid;
        logic err;
        logic band_low;
        logic drv_sup;
        logic drv_gnd;
        logic drv_tri;
        logic [PERIOD_W-1:0] pwm_per;
        logic [PERIOD_W-1:0] bit_per;
        logic [15:0] rdata;
    } poc_state_t;

    poc_state_t state_r;
    poc_state_t state_nxt;

    function automatic logic [15:0] sat16(input logic signed [31:0] v);
        if (v > 32'sd32767) begin
            return 16'h7FFF;
        end else if (v < -32'sd32768) begin
            return 16'h8000;
        end
        return v[15:0];
    endfunction

    logic signed [31:0] sum_pre;
    logic [15:0] a_pre;
    logic [15:0] a_rel;
    logic [15:0] a_mod;
    logic [15:0] m120;
    logic [16:0] m120x3;
    logic [14:0] lin_pos;
    logic [4:0] seg_idx;
    logic [9:0] seg_frac;
    logic signed [31:0] seg_delta;
    logic [15:0] lin_out;
    logic signed [31:0] scaled;
    logic [15:0] gained;
    logic [15:0] shifted;
    logic [15:0] clamped;
    logic [15:0] filt_step;
    logic [3:0] smooth_k;
    logic fault_now;
    logic [7:0] diag_eff;
    logic short_hit;
    logic locked;

    always_comb begin
        state_nxt = state_r;
        locked = state_r.user_setup_word[SETUP_LOCK];
        // arithmetic path in fixed order with saturation
        sum_pre = 32'(signed'(angle_in)) + 32'(signed'(state_r.range_preshift));
        a_pre = sat16(sum_pre);
        a_rel = sat16(32'(signed'(a_pre)) - 32'(signed'(state_r.angle_reference)));

        // segment repeat over the full turn
        if (a_rel >= 16'(2 * MOD120_SPAN)) begin
            m120 = a_rel - 16'(2 * MOD120_SPAN);
        end else if (a_rel >= MOD120_SPAN) begin
            m120 = a_rel - MOD120_SPAN;
        end else begin
            m120 = a_rel;
        end
        m120x3 = 17'(m120) * 17'd3;
        unique case (state_r.segment_repeat_select)
            2'h1: a_mod = {a_rel[13:0], 2'h0};
            2'h2: a_mod = m120x3[15:0];
            default: a_mod = a_rel;
        endcase

        // interpolation between setpoints 1024 apart
        lin_pos = a_mod[15:1];
        seg_idx = lin_pos[14:10];
        seg_frac = lin_pos[9:0];
        seg_delta = 32'(signed'(state_r.lin_point[6'(seg_idx) + 6'd1])) - 32'(signed'(state_r.lin_point[seg_idx]));
        lin_out = sat16(32'(signed'(state_r.lin_point[seg_idx])) + ((seg_delta * signed'(32'(seg_frac))) >>> 10));

        // gain then offset
        scaled = 32'(signed'(lin_out)) * 32'(signed'(state_r.output_scale));
        gained = sat16(scaled >>> SCALE_FRAC);
        shifted = sat16(32'(signed'(gained)) + 32'(signed'(state_r.output_shift)));

        // clamp to the diagnosis band
        if (signed'(shifted) < signed'(state_r.lower_output_limit)) begin
            clamped = state_r.lower_output_limit;
        end else if (signed'(shifted) > signed'(state_r.upper_output_limit)) begin
            clamped = state_r.upper_output_limit;
        end else begin
            clamped = shifted;
        end

        // low-pass, shift 0 means no filtering
        smooth_k = state_r.smoothing_select[3:0];
        filt_step = sat16((32'(signed'(clamped)) - 32'(signed'(state_r.filt))) >>> smooth_k);

        // field range
        fault_now = (signed'(magnitude_in) < signed'(state_r.field_floor))
                  || (signed'(magnitude_in) > signed'(state_r.field_ceiling));
        state_nxt.valid = sample_valid;
        if (sample_valid) begin
            state_nxt.angle_result = a_rel;
            state_nxt.filt = sat16(32'(signed'(state_r.filt)) + 32'(signed'(filt_step)));
            state_nxt.field_fault = fault_now;
            state_nxt.result = fault_now ? state_r.upper_output_limit : state_nxt.filt;
        end

        // diagnosis latch, an arriving bit always sets
        if (state_r.user_setup_word[SETUP_DIAG_LATCH]) begin
            diag_eff = state_r.diag | diag_in;
        end else begin
            diag_eff = diag_in;
        end
        state_nxt.diag = diag_eff;

        // error band and forcing
        state_nxt.band_low = locked && state_r.user_setup_word[SETUP_BAND_LOW];
        state_nxt.err = state_nxt.field_fault
                      || ((|diag_eff) && !state_r.user_setup_word[SETUP_DIAG_NOFORCE]);

        // short reaction
        state_nxt.drv_sup = 1'b0;
        state_nxt.drv_gnd = 1'b0;
        state_nxt.drv_tri = 1'b0;
        short_hit = short_high_det || short_low_det;
        unique case (state_r.user_setup_word[SETUP_SHORT_LSB +: 2])
            2'h1: begin
                state_nxt.drv_sup = short_hit && !state_nxt.band_low;
                state_nxt.drv_gnd = short_hit && state_nxt.band_low;
            end
            2'h2: begin
                state_nxt.drv_sup = short_hit && state_nxt.band_low;
                state_nxt.drv_gnd = short_hit && !state_nxt.band_low;
            end
            2'h3: state_nxt.drv_tri = short_low_det;
            default: ;
        endcase
        if (!state_nxt.drv_tri && !state_nxt.drv_sup && !state_nxt.drv_gnd && state_nxt.err) begin
            state_nxt.drv_sup = !state_nxt.band_low;
            state_nxt.drv_gnd = state_nxt.band_low;
        end

        // rate and bit time decode
        unique case (state_r.user_setup_word[SETUP_RATE_LSB +: 2])
            2'h0: state_nxt.pwm_per = PERIOD_W'(PWM_1K_CYCLES);
            2'h1: state_nxt.pwm_per = PERIOD_W'(PWM_500_CYCLES);
            2'h2: state_nxt.pwm_per = PERIOD_W'(PWM_200_CYCLES);
            default: state_nxt.pwm_per = PERIOD_W'(PWM_2K_CYCLES);
        endcase
        state_nxt.bit_per = state_r.user_setup_word[SETUP_FAST_BIT] ? PERIOD_W'(BIT_FAST_CYCLES)
                                                                     : PERIOD_W'(BIT_SLOW_CYCLES);

        // register writes, refused once locked
        if (reg_wr && !locked) begin
            unique case (reg_addr)
                ADDR_ANGLE_REFERENCE: state_nxt.angle_reference = reg_wdata;
                ADDR_RANGE_PRESHIFT: state_nxt.range_preshift = reg_wdata;
                ADDR_OUTPUT_SCALE: state_nxt.output_scale = reg_wdata;
                ADDR_OUTPUT_SHIFT: state_nxt.output_shift = reg_wdata;
                ADDR_LOWER_LIMIT: state_nxt.lower_output_limit = reg_wdata;
                ADDR_UPPER_LIMIT: state_nxt.upper_output_limit = reg_wdata;
                ADDR_FIELD_FLOOR: state_nxt.field_floor = reg_wdata;
                ADDR_FIELD_CEILING: state_nxt.field_ceiling = reg_wdata;
                ADDR_SMOOTHING: state_nxt.smoothing_select = reg_wdata;
                ADDR_USER_SETUP: state_nxt.user_setup_word = {1'b0, reg_wdata[14:0]};
                ADDR_SEGMENT_REPEAT: state_nxt.segment_repeat_select = reg_wdata[1:0];
                default: begin
                    for (int k = 0; k < LIN_POINTS; k++) begin
                        if (reg_addr == ADDR_LIN_BASE + 8'(k)) begin
                            state_nxt.lin_point[k] = reg_wdata;
                        end
                    end
                end
            endcase
        end

        // read data valid only the cycle after the strobe
        state_nxt.rdata = 16'h0000;
        if (reg_rd) begin
            unique case (reg_addr)
                ADDR_ANGLE_REFERENCE: state_nxt.rdata = state_r.angle_reference;
                ADDR_RANGE_PRESHIFT: state_nxt.rdata = state_r.range_preshift;
                ADDR_OUTPUT_SCALE: state_nxt.rdata = state_r.output_scale;
                ADDR_OUTPUT_SHIFT: state_nxt.rdata = state_r.output_shift;
                ADDR_LOWER_LIMIT: state_nxt.rdata = state_r.lower_output_limit;
                ADDR_UPPER_LIMIT: state_nxt.rdata = state_r.upper_output_limit;
                ADDR_FIELD_FLOOR: state_nxt.rdata = state_r.field_floor;
                ADDR_FIELD_CEILING: state_nxt.rdata = state_r.field_ceiling;
                ADDR_SMOOTHING: state_nxt.rdata = state_r.smoothing_select;
                ADDR_USER_SETUP: state_nxt.rdata = state_r.user_setup_word;
                ADDR_SEGMENT_REPEAT: state_nxt.rdata = {14'h0000, state_r.segment_repeat_select};
                ADDR_DIAG_STATUS: state_nxt.rdata = {7'h00, state_r.field_fault, state_r.diag};
                ADDR_ANGLE_RESULT: state_nxt.rdata = state_r.angle_result;
                ADDR_OUTPUT_VALUE: state_nxt.rdata = state_r.result;
                default: begin
                    for (int k = 0; k < LIN_POINTS; k++) begin
                        if (reg_addr == ADDR_LIN_BASE + 8'(k)) begin
                            state_nxt.rdata = state_r.lin_point[k];
                        end
                    end
                end
            endcase
        end

        if (reset) begin
            state_nxt = '0;
            state_nxt.output_scale = RST_SCALE;
            state_nxt.upper_output_limit = RST_UPPER;
            state_nxt.field_ceiling = RST_CEILING;
            state_nxt.pwm_per = PERIOD_W'(PWM_1K_CYCLES);
            state_nxt.bit_per = PERIOD_W'(BIT_SLOW_CYCLES);
            for (int k = 0; k < LIN_POINTS; k++) begin
                state_nxt.lin_point[k] = 16'(k * LIN_STEP);
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        state_r <= state_nxt;
    end

    assign reg_rdata = state_r.rdata;
    assign result_valid = state_r.valid;
    assign result_value = state_r.result;
    assign error_active = state_r.err;
    assign error_band_low = state_r.band_low;
    assign drive_supply = state_r.drv_sup;
    assign drive_ground = state_r.drv_gnd;
    assign drive_tristate = state_r.drv_tri;
    assign selftest_continuous = state_r.user_setup_word[SETUP_SELFTEST];
    assign digital_format_select = state_r.user_setup_word[SETUP_FORMAT];
    assign pulse_rate_select = state_r.user_setup_word[SETUP_RATE_LSB +: 2];
    assign pwm_period = state_r.pwm_per;
    assign bit_period = state_r.bit_per;
    assign burn_in_enable = state_r.user_setup_word[SETUP_BURN_IN];
    assign func_normal = state_r.user_setup_word[SETUP_FUNC_NORMAL];
    assign pin_talk_enable = state_r.user_setup_word[SETUP_PIN_TALK];
    assign overvolt_enable = state_r.user_setup_word[SETUP_OVERVOLT];
    assign mem_locked = state_r.user_setup_word[SETUP_LOCK];

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    lock_blocks_write_a: assert property (mem_locked && reg_wr |=> $stable(state_r.angle_reference))
        else $error("write changed a register while locked");

    unlocked_band_high_a: assert property (!mem_locked |=> !error_band_low)
        else $error("low error band used while unlocked");

    field_fault_clamp_a: assert property (sample_valid && fault_now
        |=> result_value == $past(state_r.upper_output_limit))
        else $error("field fault did not force high clamp");

    clamp_band_a: assert property (result_valid && !state_r.field_fault && $past(smooth_k) == 4'h0
        |-> signed'(result_value) <= signed'($past(state_r.upper_output_limit)))
        else $error("output above upper limit");

    diag_latch_hold_a: assert property (
        state_r.user_setup_word[SETUP_DIAG_LATCH] && state_r.diag[0] |=> state_r.diag[0])
        else $error("latched diagnosis bit dropped");

    fast_rate_a: assert property (pulse_rate_select == 2'h3 ##1 pulse_rate_select == 2'h3
        |-> pwm_period == PERIOD_W'(PWM_2K_CYCLES))
        else $error("pwm period wrong for fastest rate");

    bit_time_a: assert property ($rose(state_r.user_setup_word[SETUP_FAST_BIT])
        |=> bit_period == PERIOD_W'(BIT_FAST_CYCLES))
        else $error("bit period not fast after select");

    short_tristate_a: assert property (
        state_r.user_setup_word[SETUP_SHORT_LSB +: 2] == 2'h3 && short_low_det |=> drive_tristate && !drive_supply)
        else $error("short did not tristate output");

    diag_force_a: assert property (
        |diag_in && !state_r.user_setup_word[SETUP_DIAG_NOFORCE] && !state_r.user_setup_word[SETUP_LOCK]
        && state_r.user_setup_word[SETUP_SHORT_LSB +: 2] == 2'h0 |=> error_active ##0 drive_supply)
        else $error("diagnosis error did not force supply band");

    read_setup_a: assert property (reg_rd && reg_addr == ADDR_USER_SETUP
        |=> reg_rdata == $past(state_r.user_setup_word))
        else $error("read data mismatch");

    lock_write_c: cover property (reg_wr && reg_addr == ADDR_USER_SETUP && reg_wdata[0]);
    field_fault_c: cover property (sample_valid && fault_now);
    mod120_c: cover property (sample_valid && state_r.segment_repeat_select == 2'h2);
    short_react_c: cover property (short_hit && state_r.user_setup_word[SETUP_SHORT_LSB +: 2] != 2'h0);
    diag_latch_c: cover property (state_r.user_setup_word[SETUP_DIAG_LATCH] && |diag_in);
endmodule
`default_nettype wire

/* File: poc_ctrl_model.sv */
// external controller model: captures each conditioned output frame
`default_nettype none
module poc_ctrl_model (
    // clock
    input wire logic sys_clk,
    // sensor output
    input wire logic result_valid,
    input wire logic [15:0] result_value,
    // captured frame
    output logic [15:0] seen_value = 16'h0000,
    output logic [31:0] n_frames = 32'h0000_0000
);
    timeunit 1ns;
    timeprecision 1ps;
    // value taken only in the one cycle that the valid pulse stands
    always @(posedge sys_clk) begin
        if (result_valid) begin
            seen_value <= result_value;
            n_frames <= n_frames + 32'h0000_0001;
        end
    end
endmodule
`default_nettype wire

/* File: tb_position_output_config.sv */
// testbench: register port and sample path of the position output stage
`default_nettype none
module tb_position_output_config;
    timeunit 1ns;
    timeprecision 1ps;
    import poc_pkg::*;
    localparam int PER[4] = '{50, 100, 250, 25};
    localparam int BSLOW = 40;
    localparam int BFAST = 10;
    logic sys_clk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, sample_valid = 1'b0;
    logic short_high_det = 1'b0, short_low_det = 1'b0, result_valid, error_active, error_band_low;
    logic drive_supply, drive_ground, drive_tristate, selftest_continuous, digital_format_select;
    logic burn_in_enable, func_normal, pin_talk_enable, overvolt_enable, mem_locked;
    logic [1:0] pulse_rate_select;
    logic [7:0] reg_addr = 8'h00, diag_in = 8'h00;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata, angle_in = 16'h0000, magnitude_in = 16'h1000;
    logic [15:0] result_value, seen_value;
    logic [19:0] pwm_period, bit_period;
    logic [31:0] n_frames;
    int failures = 0, n_checks = 0;
    poc_output_stage #(.BIT_SLOW_CYCLES(BSLOW), .BIT_FAST_CYCLES(BFAST), .PWM_1K_CYCLES(PER[0]),
        .PWM_500_CYCLES(PER[1]), .PWM_200_CYCLES(PER[2]), .PWM_2K_CYCLES(PER[3])) DUT (.sys_clk(sys_clk),
        .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .sample_valid(sample_valid), .angle_in(angle_in), .magnitude_in(magnitude_in),
        .diag_in(diag_in), .short_high_det(short_high_det), .short_low_det(short_low_det),
        .result_valid(result_valid), .result_value(result_value), .error_active(error_active),
        .error_band_low(error_band_low), .drive_supply(drive_supply), .drive_ground(drive_ground),
        .drive_tristate(drive_tristate), .selftest_continuous(selftest_continuous),
        .digital_format_select(digital_format_select), .pulse_rate_select(pulse_rate_select),
        .pwm_period(pwm_period), .bit_period(bit_period), .burn_in_enable(burn_in_enable),
        .func_normal(func_normal), .pin_talk_enable(pin_talk_enable), .overvolt_enable(overvolt_enable),
        .mem_locked(mem_locked));
    poc_ctrl_model ctrl (.sys_clk(sys_clk), .result_valid(result_valid), .result_value(result_value),
        .seen_value(seen_value), .n_frames(n_frames));
    initial begin
        forever #2.5 sys_clk = ~sys_clk;
    end
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [19:0] e, input logic [19:0] g);
        n_checks++;
        if (g !== e) begin
            failures++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    task automatic rst();
        @(posedge sys_clk);
        reset <= 1'b1;
        repeat (16) @(posedge sys_clk);
        reset <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(negedge sys_clk);
        chk("reg_rdata", {4'h0, e}, {4'h0, reg_rdata});
    endtask
    // one sample, then the frame seen by the controller model
    task automatic smp(input logic [15:0] a, input logic [15:0] m, input logic [15:0] e);
        int i;
        @(posedge sys_clk);
        sample_valid <= 1'b1;
        angle_in <= a;
        magnitude_in <= m;
        @(posedge sys_clk);
        sample_valid <= 1'b0;
        for (i = 0; i < 8 && result_valid !== 1'b1; i++) @(negedge sys_clk);
        if (i == 8) begin
            failures++;
            $display("mismatch result_valid expected 1 seen timeout");
            conclude();
        end
        @(negedge sys_clk);
        chk("result_value", {4'h0, e}, {4'h0, seen_value});
    endtask
    initial begin
        rst();
        tick(3);
        rd(ADDR_OUTPUT_SCALE, RST_SCALE);
        rd(ADDR_UPPER_LIMIT, RST_UPPER);
        rd(ADDR_FIELD_CEILING, RST_CEILING);
        rd(ADDR_LIN_BASE + 8'h20, 16'h8000);
        rd(ADDR_ANGLE_REFERENCE, 16'h0000);
        rd(8'h10, 16'h0000);
        chk("periods", 20'(PER[0] + BSLOW), pwm_period + bit_period);
        $display("test reset values done");
        wr(ADDR_USER_SETUP, 16'hFFFE);
        rd(ADDR_USER_SETUP, 16'h7FFE);
        chk("setup bits", 20'h001FE, {11'h0, selftest_continuous, digital_format_select, pulse_rate_select,
            burn_in_enable, func_normal, pin_talk_enable, overvolt_enable, mem_locked});
        for (int r = 0; r < 4; r++) begin
            wr(ADDR_USER_SETUP, 16'(r << 10));
            tick(3);
            chk("pwm_period", 20'(PER[r]), pwm_period);
        end
        wr(ADDR_USER_SETUP, 16'h2000);
        tick(3);
        chk("bit_period", 20'(BFAST), bit_period);
        wr(ADDR_USER_SETUP, 16'h0002);
        $display("test setup word done");
        smp(16'h4000, 16'h1000, 16'h1000);
        wr(ADDR_ANGLE_REFERENCE, 16'h2000);
        smp(16'h6000, 16'h1000, 16'h1000);
        wr(ADDR_ANGLE_REFERENCE, 16'h0000);
        smp(16'h4000, 16'h1000, 16'h1000);
        rd(ADDR_ANGLE_RESULT, 16'h4000);
        wr(ADDR_OUTPUT_SHIFT, 16'h0800);
        smp(16'h4000, 16'h1000, 16'h1800);
        wr(ADDR_OUTPUT_SHIFT, 16'h7FFF);
        smp(16'h4000, 16'h1000, 16'h4000);
        wr(ADDR_OUTPUT_SHIFT, 16'h0000);
        wr(ADDR_UPPER_LIMIT, 16'h0800);
        smp(16'h4000, 16'h1000, 16'h0800);
        wr(ADDR_UPPER_LIMIT, 16'h4000);
        wr(ADDR_SEGMENT_REPEAT, 16'h0001);
        smp(16'h1000, 16'h1000, 16'h1000);
        wr(ADDR_SEGMENT_REPEAT, 16'h0002);
        smp(16'h2000, 16'h1000, 16'h1800);
        wr(ADDR_SEGMENT_REPEAT, 16'h0000);
        smp(16'h4000, 16'h1000, 16'h1000);
        wr(ADDR_SMOOTHING, 16'h0001);
        smp(16'h0000, 16'h1000, 16'h0800);
        wr(ADDR_SMOOTHING, 16'h0000);
        wr(ADDR_RANGE_PRESHIFT, 16'h1000);
        wr(ADDR_OUTPUT_SCALE, 16'h0400);
        smp(16'h3000, 16'h1000, 16'h2000);
        wr(ADDR_RANGE_PRESHIFT, 16'h0000);
        wr(ADDR_OUTPUT_SCALE, RST_SCALE);
        wr(ADDR_LOWER_LIMIT, 16'h0800);
        smp(16'h0000, 16'h1000, 16'h0800);
        wr(ADDR_LOWER_LIMIT, 16'h0000);
        wr(ADDR_LIN_BASE + 8'h01, 16'h0600);
        smp(16'h0400, 16'h1000, 16'h0180);
        wr(ADDR_LIN_BASE + 8'h01, 16'h0400);
        wr(ADDR_FIELD_FLOOR, 16'h0100);
        smp(16'h4000, 16'h0010, 16'h4000);
        chk("error_active", 20'h1, {19'h0, error_active});
        wr(ADDR_FIELD_FLOOR, 16'h0000);
        wr(ADDR_FIELD_CEILING, 16'h2000);
        smp(16'h4000, 16'h3000, 16'h4000);
        wr(ADDR_FIELD_CEILING, RST_CEILING);
        $display("test sample path done");
        wr(ADDR_USER_SETUP, 16'h0004);
        @(posedge sys_clk);
        diag_in <= 8'h01;
        @(posedge sys_clk);
        diag_in <= 8'h00;
        smp(16'h4000, 16'h1000, 16'h1000);
        rd(ADDR_DIAG_STATUS, 16'h0001);
        chk("diag drive", 20'h3, {18'h0, error_active, drive_supply});
        chk("n_frames", 20'd16, n_frames[19:0]);
        $display("test diagnosis done");
        rst();
        short_high_det <= 1'b1;
        short_low_det <= 1'b1;
        for (int m = 1; m < 4; m++) begin
            wr(ADDR_USER_SETUP, 16'(m << 8));
            tick(3);
            chk("short rails", 20'(4 >> (m - 1)), {17'h0, drive_supply, drive_ground, drive_tristate});
        end
        @(posedge sys_clk);
        short_high_det <= 1'b0;
        short_low_det <= 1'b0;
        wr(ADDR_USER_SETUP, 16'h0080);
        tick(3);
        chk("band unlocked", 20'h0, {19'h0, error_band_low});
        wr(ADDR_USER_SETUP, 16'h0081);
        tick(3);
        chk("band locked", 20'h3, {18'h0, mem_locked, error_band_low});
        wr(ADDR_ANGLE_REFERENCE, 16'h1234);
        rd(ADDR_ANGLE_REFERENCE, 16'h0000);
        rd(ADDR_USER_SETUP, 16'h0081);
        $display("test shorts and lock done");
        conclude();
    end
endmodule
`default_nettype wire
